// ===== hw/ahp_cfg.svh
// Constants for the asynchronous host register port
`ifndef AHP_CFG_SVH
`define AHP_CFG_SVH

// ----------------------------------------------------------------------
// Widths and synchroniser depth
// ----------------------------------------------------------------------
`define AHP_ADDR_W        8
`define AHP_DATA_W        8
`define AHP_SYNC_STAGES   3

// ----------------------------------------------------------------------
// Bus style select codes and the strap bit that is sampled
// ----------------------------------------------------------------------
`define AHP_STYLE_SEP     2'h0
`define AHP_STYLE_DSTB    2'h1
`define AHP_STYLE_SEP_S   2'h2
`define AHP_STYLE_DSTB_S  2'h3
`define AHP_STYLE_BIT     0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define AHP_ADDR_RST      8'h00
`define AHP_DATA_RST      8'h00

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define AHP_CLK_PERIOD_NS 10
`define AHP_ACK_MAX_NS    90
`define AHP_ACK_MAX_CYC   (`AHP_ACK_MAX_NS / `AHP_CLK_PERIOD_NS)

`endif

// ===== hw/ahp_pkg.sv
// Types shared by the asynchronous host register port
package ahp_pkg;

  // Host pins as seen after synchronising
  typedef struct packed {
    logic       cs_n;
    logic       ale;
    logic       strobe_n;
    logic       wr_dir;
    logic [7:0] addr;
    logic [7:0] data;
  } ahp_pins_t;

  // Access sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RD   = 2'b01,
    ST_WR   = 2'b10,
    ST_DONE = 2'b11
  } ahp_state_t;

endpackage : ahp_pkg

// ===== hw/ahp_regmem.sv
// Register storage with registered read data
`timescale 1ns/10ps
`include "ahp_cfg.svh"

module ahp_regmem #(
  parameter int AW = `AHP_ADDR_W,
  parameter int DW = `AHP_DATA_W
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst,
  // Write port
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  // Read port
  input  wire logic          rd_en,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data
);

  logic [DW-1:0] mem_ff [0:(1<<AW)-1];

  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem_ff[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rd_data <= '0;
    end
    else if (rd_en)
    begin
      rd_data <= mem_ff[rd_addr];
    end
  end

endmodule : ahp_regmem

// ===== hw/ahp_host_port.sv
// Asynchronous parallel host port onto the on-chip register store
`timescale 1ns/10ps
`include "ahp_cfg.svh"

module ahp_host_port #(
  parameter int AW = `AHP_ADDR_W,
  parameter int DW = `AHP_DATA_W
) (
  // Clock and reset
  input  wire logic          REF_CLK,
  input  wire logic          RESET,
  // Style strap
  input  wire logic [1:0]    HOST_BUS_STYLE_SELECT,
  // Host control pins
  input  wire logic          CS_N,
  input  wire logic          ADDR_LATCH,
  input  wire logic          READ_OR_DATA_STROBE_N,
  input  wire logic          WRITE_OR_DIR,
  input  wire logic [AW-1:0] ADDR,
  // Bidirectional data bus
  input  wire logic [DW-1:0] DATA_IN,
  output logic      [DW-1:0] DATA_OUT,
  output logic               DATA_OE,
  // Acknowledge
  output logic               READY_N
);

  localparam int ACK_MAX = `AHP_ACK_MAX_CYC;

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  // Three stages; a bit moves only once stages two and three agree.

  ahp_pkg::ahp_pins_t pin_raw;
  ahp_pkg::ahp_pins_t sync1_ff;
  ahp_pkg::ahp_pins_t sync2_ff;
  ahp_pkg::ahp_pins_t sync3_ff;
  ahp_pkg::ahp_pins_t filt_ff;
  ahp_pkg::ahp_pins_t nxt_filt;
  localparam ahp_pkg::ahp_pins_t rst_pins = {1'b1, 1'b0, 1'b1, 1'b1,
                                             `AHP_ADDR_RST, `AHP_DATA_RST};

  always_comb
  begin
    pin_raw.cs_n     = CS_N;
    pin_raw.ale      = ADDR_LATCH;
    pin_raw.strobe_n = READ_OR_DATA_STROBE_N;
    pin_raw.wr_dir   = WRITE_OR_DIR;
    pin_raw.addr     = ADDR;
    pin_raw.data     = DATA_IN;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      sync1_ff <= rst_pins;
      sync2_ff <= rst_pins;
      sync3_ff <= rst_pins;
    end
    else
    begin
      sync1_ff <= pin_raw;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  assign nxt_filt = (~(sync2_ff ^ sync3_ff) & sync3_ff)
                  | ((sync2_ff ^ sync3_ff) & filt_ff);

  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
      filt_ff <= rst_pins;
    else
      filt_ff <= nxt_filt;
  end

  // ----------------------------------------------------------------------
  // Style strap
  // ----------------------------------------------------------------------
  // Strap bit 0 sampled on every clock out of reset; synchronous codes reuse the
  // asynchronous handshake of the matching strobe style.

  logic style_dstb_ff;

  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
      style_dstb_ff <= 1'b0;
    else
      style_dstb_ff <= HOST_BUS_STYLE_SELECT[`AHP_STYLE_BIT];
  end

  // ----------------------------------------------------------------------
  // Address latch
  // ----------------------------------------------------------------------

  logic          ale_prev_ff;
  logic [AW-1:0] addr_lat_ff;
  logic [AW-1:0] eff_addr;
  logic          ale_fall;

  assign ale_fall = ale_prev_ff & ~filt_ff.ale;

  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
      ale_prev_ff <= 1'b0;
    else
      ale_prev_ff <= filt_ff.ale;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
      addr_lat_ff <= `AHP_ADDR_RST;
    else if (filt_ff.ale)
      addr_lat_ff <= filt_ff.addr;
  end

  // Open while the latch enable is high
  assign eff_addr = filt_ff.ale ? filt_ff.addr : addr_lat_ff;

  // ----------------------------------------------------------------------
  // Strobe decode
  // ----------------------------------------------------------------------

  logic rd_req;
  logic wr_req;
  logic released;

  always_comb
  begin
    if (style_dstb_ff)
    begin
      rd_req   = ~filt_ff.strobe_n & filt_ff.wr_dir;
      wr_req   = ~filt_ff.strobe_n & ~filt_ff.wr_dir;
      released = filt_ff.strobe_n;
    end
    else
    begin
      rd_req   = ~filt_ff.strobe_n;
      wr_req   = ~filt_ff.wr_dir;
      released = filt_ff.strobe_n & filt_ff.wr_dir;
    end
    released = released | filt_ff.cs_n;
  end

  // ----------------------------------------------------------------------
  // Access sequencer
  // ----------------------------------------------------------------------
  // Returning to idle needs the strobe released or chip select high, so a strobe
  // held under chip select cannot start a second store.

  ahp_pkg::ahp_state_t state_ff;
  ahp_pkg::ahp_state_t nxt_state;
  logic                start_ok;

  assign start_ok = ~filt_ff.cs_n;

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ahp_pkg::ST_IDLE:
        if (start_ok && rd_req)
          nxt_state = ahp_pkg::ST_RD;
        else if (start_ok && wr_req)
          nxt_state = ahp_pkg::ST_WR;
      ahp_pkg::ST_RD:   nxt_state = ahp_pkg::ST_DONE;
      ahp_pkg::ST_WR:   nxt_state = ahp_pkg::ST_DONE;
      ahp_pkg::ST_DONE:
        if (released)
          nxt_state = ahp_pkg::ST_IDLE;
      default:          nxt_state = ahp_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
      state_ff <= ahp_pkg::ST_IDLE;
    else
      state_ff <= nxt_state;
  end

  // ----------------------------------------------------------------------
  // Register store access
  // ----------------------------------------------------------------------

  logic          idle_start;
  logic          mem_rd_en;
  logic          mem_we_ff;
  logic [AW-1:0] wr_addr_ff;
  logic [DW-1:0] wr_data_ff;
  logic [DW-1:0] mem_rdata;

  assign idle_start = (state_ff == ahp_pkg::ST_IDLE) && start_ok;
  assign mem_rd_en  = idle_start && rd_req;

  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      mem_we_ff  <= 1'b0;
      wr_addr_ff <= `AHP_ADDR_RST;
      wr_data_ff <= `AHP_DATA_RST;
    end
    else
    begin
      mem_we_ff  <= idle_start && !rd_req && wr_req;
      wr_addr_ff <= eff_addr;
      wr_data_ff <= filt_ff.data;
    end
  end

  ahp_regmem #(
    .AW (AW),
    .DW (DW)
  ) u_regmem (
    .clk     (REF_CLK),
    .rst     (RESET),
    .wr_en   (mem_we_ff),
    .wr_addr (wr_addr_ff),
    .wr_data (wr_data_ff),
    .rd_en   (mem_rd_en),
    .rd_addr (eff_addr),
    .rd_data (mem_rdata)
  );

  // ----------------------------------------------------------------------
  // Host outputs
  // ----------------------------------------------------------------------

  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      DATA_OUT <= `AHP_DATA_RST;
      DATA_OE  <= 1'b0;
    end
    else if (state_ff == ahp_pkg::ST_RD)
    begin
      DATA_OUT <= mem_rdata;
      DATA_OE  <= 1'b1;
    end
    else if (nxt_state == ahp_pkg::ST_IDLE)
      DATA_OE  <= 1'b0;
  end

  // Store lands on the same edge that drops ready
  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
      READY_N <= 1'b1;
    else
      READY_N <= !(nxt_state == ahp_pkg::ST_DONE);
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RESET);

  a_addr_capture: assert property (ale_fall |->
    addr_lat_ff == $past(filt_ff.addr))
    else $error("address not held from latch fall");
  a_addr_transparent: assert property (
    mem_we_ff && $past(filt_ff.ale) |-> wr_addr_ff == $past(filt_ff.addr))
    else $error("address path not transparent");
  a_cs_gates: assert property (
    state_ff == ahp_pkg::ST_IDLE && filt_ff.cs_n |=>
    state_ff == ahp_pkg::ST_IDLE)
    else $error("access started without chip select");
  a_read_drive: assert property (
    state_ff == ahp_pkg::ST_RD |=>
    DATA_OE && !READY_N && DATA_OUT == $past(mem_rdata))
    else $error("read data not driven with ready");
  a_read_ack_bound: assert property (
    idle_start && rd_req |-> ##[1:ACK_MAX] !READY_N && DATA_OE)
    else $error("read acknowledge late");
  a_write_single: assert property (mem_we_ff |=>
    !mem_we_ff && !READY_N)
    else $error("write repeated or not acknowledged");
  a_write_stored: assert property (
    $fell(READY_N) && !DATA_OE |-> $past(mem_we_ff))
    else $error("write acknowledged before store");
  a_release: assert property (
    state_ff == ahp_pkg::ST_DONE && released |=>
    READY_N && !DATA_OE)
    else $error("ready or drivers held after release");
  a_dir_pick: assert property (
    style_dstb_ff && idle_start && !filt_ff.strobe_n |=>
    state_ff == ($past(filt_ff.wr_dir) ? ahp_pkg::ST_RD : ahp_pkg::ST_WR))
    else $error("direction line misread");

  c_read_done: cover property (state_ff == ahp_pkg::ST_RD ##1 !READY_N);
  c_write_done: cover property (mem_we_ff ##1 !READY_N);
  c_dstb_read: cover property (style_dstb_ff && mem_rd_en);

endmodule : ahp_host_port

// ===== bench/ahp_host_model.sv
// Host processor model driving the asynchronous register port
`timescale 1ns/10ps

module ahp_host_model (
  // Clock
  input  wire logic       clk,
  // Host pins
  output logic            cs_n,
  output logic            ale,
  output logic            strb_n,
  output logic            wod,
  output logic [7:0]      addr,
  // Data bus and acknowledge
  input  wire logic [7:0] dev_data,
  input  wire logic       dev_oe,
  input  wire logic       rdy_n,
  output logic [7:0]      data_in
);
  logic       oe;
  logic [7:0] drv;

  // Released bus shows the inverse, never a stale byte
  assign data_in = dev_oe ? dev_data : (oe ? drv : ~drv);

  initial
  begin
    cs_n   = 1'b1;
    ale    = 1'b0;
    strb_n = 1'b1;
    wod    = 1'b1;
    addr   = 8'h00;
    oe     = 1'b0;
    drv    = 8'h00;
  end

  task automatic access(input logic [1:0] sty, input logic wr, sel, tr,
                        input logic [7:0] a, d, input int hold,
                        output logic [7:0] q, output int lat);
    int n;
    lat = 0;
    n   = 0;
    q   = 8'hxx;
    @(posedge clk);
    #1;
    addr = a;
    cs_n = ~sel;
    ale  = 1'b1;
    drv  = d;
    oe   = wr;
    // Chip select to strobe is at least 65 ns
    repeat (7) @(posedge clk);
    #1;
    if (!tr)
      ale = 1'b0;
    repeat (6) @(posedge clk);
    #1;
    if (!tr)
      addr = ~a;
    if (sty[0])
      wod = ~wr;
    @(posedge clk);
    #1;
    if (!sty[0] && wr)
      wod = 1'b0;
    else
      strb_n = 1'b0;
    // Outputs read one step after the edge that launches them
    while (rdy_n !== 1'b0 && lat < 12)
    begin
      @(posedge clk);
      #1;
      lat++;
    end
    if (dev_oe === 1'b1)
      q = dev_data;
    // Bus turned over while held: a second store would show
    if (hold > 0)
      drv = ~d;
    repeat (hold)
    begin
      @(posedge clk);
      #1;
    end
    strb_n = 1'b1;
    if (!sty[0])
      wod = 1'b1;
    while (rdy_n !== 1'b1 && n < 12)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    oe   = 1'b0;
    cs_n = 1'b1;
    ale  = tr;
  endtask : access

endmodule : ahp_host_model

// ===== bench/tb_async_host_register_port.sv
// Self-checking bench for the asynchronous host register port
`timescale 1ns/10ps

module tb_async_host_register_port;
  logic       ref_clk;
  logic       reset;
  logic [1:0] style;
  logic       cs_n;
  logic       ale;
  logic       strb_n;
  logic       wod;
  logic [7:0] addr;
  logic [7:0] data_in;
  logic [7:0] data_out;
  logic       data_oe;
  logic       ready_n;
  logic [7:0] q;
  int         num_errors;
  int         checks;

  ahp_host_port dut (
    .REF_CLK               (ref_clk),
    .RESET                 (reset),
    .HOST_BUS_STYLE_SELECT (style),
    .CS_N                  (cs_n),
    .ADDR_LATCH            (ale),
    .READ_OR_DATA_STROBE_N (strb_n),
    .WRITE_OR_DIR          (wod),
    .ADDR                  (addr),
    .DATA_IN               (data_in),
    .DATA_OUT              (data_out),
    .DATA_OE               (data_oe),
    .READY_N               (ready_n)
  );

  ahp_host_model host (
    .clk      (ref_clk),
    .cs_n     (cs_n),
    .ale      (ale),
    .strb_n   (strb_n),
    .wod      (wod),
    .addr     (addr),
    .dev_data (data_out),
    .dev_oe   (data_oe),
    .rdy_n    (ready_n),
    .data_in  (data_in)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ----
  // Checking
  // ----
  task automatic chk(input logic [7:0] seen, exp, input string what);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %0t: %s seen %h want %h", $time, what, seen, exp);
    end
  endtask : chk

  task automatic wrap_up;
    if (num_errors == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up

  task automatic acc(input logic wr, sel, tr, input logic [7:0] a, d,
                     input int hold);
    int lat;
    host.access(style, wr, sel, tr, a, d, hold, q, lat);
    if (sel)
      chk({7'h00, lat <= 9}, 8'h01, "ack latency");
    else
      chk({7'h00, lat == 12}, 8'h01, "ack unselected");
    chk({7'h00, data_oe}, 8'h00, "drivers off");
    chk({7'h00, ready_n}, 8'h01, "ready off");
  endtask : acc

  // ----
  // Scenarios
  // ----
  task automatic t_reset;
    chk({7'h00, data_oe}, 8'h00, "oe at reset");
    chk({7'h00, ready_n}, 8'h01, "ready at reset");
  endtask : t_reset

  task automatic t_styles;
    for (int s = 0; s < 4; s++)
    begin
      style = 2'(s);
      acc(1'b1, 1'b1, 1'b0, 8'h00, 8'ha5 ^ 8'(s), 0);
      acc(1'b1, 1'b1, 1'b0, 8'hff, 8'h3c ^ 8'(s), 0);
      acc(1'b0, 1'b1, 1'b0, 8'h00, 8'h00, 0);
      chk(q, 8'ha5 ^ 8'(s), "read low");
      acc(1'b0, 1'b1, 1'b0, 8'hff, 8'h00, 0);
      chk(q, 8'h3c ^ 8'(s), "read high");
    end
  endtask : t_styles

  task automatic t_transparent;
    for (int s = 0; s < 2; s++)
    begin
      style = 2'(s);
      acc(1'b1, 1'b1, 1'b1, 8'h81, 8'h5a ^ 8'(s), 0);
      acc(1'b0, 1'b1, 1'b1, 8'h81, 8'h00, 0);
      chk(q, 8'h5a ^ 8'(s), "transparent");
    end
  endtask : t_transparent

  task automatic t_cs_gate;
    for (int s = 0; s < 2; s++)
    begin
      style = 2'(s);
      acc(1'b1, 1'b1, 1'b0, 8'h42, 8'h77, 0);
      acc(1'b1, 1'b0, 1'b0, 8'h42, 8'h88, 0);
      acc(1'b0, 1'b0, 1'b0, 8'h42, 8'h00, 0);
      acc(1'b0, 1'b1, 1'b0, 8'h42, 8'h00, 0);
      chk(q, 8'h77, "unselected write");
    end
  endtask : t_cs_gate

  task automatic t_hold_once;
    for (int s = 0; s < 2; s++)
    begin
      style = 2'(s);
      acc(1'b1, 1'b1, 1'b0, 8'h99, 8'hc3, 8);
      acc(1'b0, 1'b1, 1'b0, 8'h99, 8'h00, 8);
      chk(q, 8'hc3, "held write");
    end
  endtask : t_hold_once

  initial
  begin
    num_errors = 0;
    checks     = 0;
    reset      = 1'b1;
    style      = 2'h0;
    repeat (2) @(posedge ref_clk);
    #1;
    reset = 1'b0;
    t_reset();
    t_styles();
    t_transparent();
    t_cs_gate();
    t_hold_once();
    wrap_up();
  end

  // Whole run is under a thousand cycles
  initial
  begin
    #100000;
    num_errors++;
    wrap_up();
  end

endmodule : tb_async_host_register_port
